// *** pcc_mult_decode.sv ***
// Purpose: Decodes a four-bit auxiliary PLL multiplier code into its factor
// Assumes: Purely combinational; the caller registers the result
// Notes: Reserved codes give factor zero with valid low
module pcc_mult_decode
    import pcc_pkg::*;
(
    input wire logic [3:0] code,
    output logic [4:0] factor,
    output logic valid
);

    always_comb
    begin
        factor = 5'h00;
        valid = 1'b0;
        unique case (code)
            4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC:
            begin
                factor = {1'b0, code} + 5'h02;
                valid = 1'b1;
            end
            4'hE:
            begin
                factor = 5'h10;
                valid = 1'b1;
            end
            4'hF:
            begin
                factor = 5'h14;
                valid = 1'b1;
            end
            default:
            begin
                factor = 5'h00;
                valid = 1'b0;
            end
        endcase
    end

endmodule : pcc_mult_decode

// *** pcc_params.svh ***
// Purpose: Offsets, field positions, masks and reset values of the clock config slice
// Assumes: Included by bare name wherever these constants are needed
// Notes: Definitions only
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

`define PCC_OFF_AHBRST 12'h028
`define PCC_OFF_CFG1 12'h02C
`define PCC_OFF_DSV 12'h034

`define PCC_RST_AHBRST 32'h0000_0000
`define PCC_RST_CFG1 32'h0000_0000
`define PCC_RST_DSV 32'h0000_0000

`define PCC_MASK_AHBRST 32'h0000_1000
`define PCC_MASK_CFG1 32'h6007_FFFF
`define PCC_MASK_DSV 32'h0000_0003

`define PCC_BIT_USBRST 12
`define PCC_BIT_PLLSRC 30
`define PCC_BIT_ADCMSB 29
`define PCC_BIT_I2SB 18
`define PCC_BIT_I2SA 17
`define PCC_BIT_PDASEL 16
`define PCC_MSB_PLLC 15
`define PCC_LSB_PLLC 12
`define PCC_MSB_PLLB 11
`define PCC_LSB_PLLB 8
`define PCC_MSB_PDB 7
`define PCC_LSB_PDB 4
`define PCC_MSB_PDA 3
`define PCC_LSB_PDA 0
`define PCC_MSB_DSV 1
`define PCC_LSB_DSV 0

`endif

// *** pcc_pkg.sv ***
// Purpose: Types of the clock config slice
// Assumes: Nothing
// Notes: State of the register block is one packed struct
package pcc_pkg;

    typedef enum logic [1:0] {
        PCC_DSV_1V0,
        PCC_DSV_0V9,
        PCC_DSV_0V8,
        PCC_DSV_1V2
    } pcc_dsv_t;

    typedef struct packed {
        logic [31:0] ahbrst;
        logic [31:0] cfg1;
        logic [31:0] dsv;
        logic [31:0] prdata;
        logic rd_err;
        logic [4:0] pll_c_factor;
        logic pll_c_ok;
        logic [4:0] pll_b_factor;
        logic pll_b_ok;
        logic [4:0] prediv_a_div;
        logic [4:0] prediv_b_div;
        logic [3:0] adc_psc;
    } pcc_state_t;

endpackage : pcc_pkg

// *** pcc_regs.sv ***
// Purpose: APB register slice for USB reset, second clock config and deep-sleep voltage
// Assumes: Single clock ref_clk, synchronous active-high rst, APB4 master with pstrb
// Notes: Zero-wait slave; read data registered in the setup cycle
// Behaviour
// - Bit 12 holds USB full-speed core reset
// - Bit 30 picks crystal or 48 MHz RC
// - Bit 29 is ADC prescaler top bit
// - Bit 18 picks second I2S clock source
// - Bit 17 picks first I2S clock source
// - Bit 16 picks pre-divider A input
// - PLL C multiplier code decode, reserved flagged
// - PLL B multiplier uses same decode
// - Pre-divider B divides by field plus one
// - Pre-divider A divides by field plus one
// - Pre-divider A bit 0 shared with first config
// - Deep-sleep voltage field selects core voltage
// - Byte, half-word and word writes by lanes
// - All three registers reset to zero
`include "pcc_params.svh"

module pcc_regs
    import pcc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg0_prediv_lsb_we,
    input wire logic cfg0_prediv_lsb_wdata,
    input wire logic cfg0_adc_psc_hi,
    input wire logic [1:0] cfg0_adc_psc_lo,
    output logic usb_fs_core_reset,
    output logic main_pll_source_select,
    output logic i2s_b_clock_select,
    output logic i2s_a_clock_select,
    output logic prediv_a_input_select,
    output logic prediv_a_lsb,
    output logic [3:0] adc_prescaler,
    output logic [4:0] pll_c_multiplier,
    output logic pll_c_multiplier_valid,
    output logic [4:0] pll_b_multiplier,
    output logic pll_b_multiplier_valid,
    output logic [4:0] prediv_a_divisor,
    output logic [4:0] prediv_b_divisor,
    output logic [1:0] deep_sleep_core_voltage
);

    pcc_state_t s_q;
    pcc_state_t s_d;
    logic [4:0] pll_c_dec;
    logic pll_c_dec_ok;
    logic [4:0] pll_b_dec;
    logic pll_b_dec_ok;
    logic sel_ahbrst;
    logic sel_cfg1;
    logic sel_dsv;
    logic wr_access;
    logic setup;

    // Word match ignoring the byte offset inside the word
    function automatic logic word_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        logic [ADDR_W-1:0] o;
        o = ADDR_W'(off);
        word_hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
    endfunction : word_hit

    // Merge write data by byte lanes, then drop reserved bits
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [31:0] mask
    );
        logic [31:0] bm;
        bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        lane_merge = ((old & ~bm) | (wdata & bm)) & mask;
    endfunction : lane_merge

    // Divider ratio is field plus one
    function automatic logic [4:0] div_ratio(input logic [3:0] field);
        div_ratio = {1'b0, field} + 5'h01;
    endfunction : div_ratio

    pcc_mult_decode u_pll_c_dec
    (
        .code(s_q.cfg1[`PCC_MSB_PLLC:`PCC_LSB_PLLC]),
        .factor(pll_c_dec),
        .valid(pll_c_dec_ok)
    );

    pcc_mult_decode u_pll_b_dec
    (
        .code(s_q.cfg1[`PCC_MSB_PLLB:`PCC_LSB_PLLB]),
        .factor(pll_b_dec),
        .valid(pll_b_dec_ok)
    );

    assign sel_ahbrst = word_hit(paddr, `PCC_OFF_AHBRST);
    assign sel_cfg1 = word_hit(paddr, `PCC_OFF_CFG1);
    assign sel_dsv = word_hit(paddr, `PCC_OFF_DSV);
    assign setup = psel & ~penable;
    assign wr_access = psel & penable & pwrite;

    always_comb
    begin
        s_d = s_q;
        if (wr_access && sel_ahbrst)
        begin
            s_d.ahbrst = lane_merge(s_q.ahbrst, pwdata, pstrb, `PCC_MASK_AHBRST);
        end
        if (wr_access && sel_cfg1)
        begin
            s_d.cfg1 = lane_merge(s_q.cfg1, pwdata, pstrb, `PCC_MASK_CFG1);
        end
        if (cfg0_prediv_lsb_we)
        begin
            s_d.cfg1[`PCC_LSB_PDA] = cfg0_prediv_lsb_wdata;
        end
        if (wr_access && sel_dsv)
        begin
            s_d.dsv = lane_merge(s_q.dsv, pwdata, pstrb, `PCC_MASK_DSV);
        end
        if (setup)
        begin
            s_d.rd_err = ~(sel_ahbrst | sel_cfg1 | sel_dsv);
            if (sel_ahbrst)
            begin
                s_d.prdata = s_q.ahbrst & `PCC_MASK_AHBRST;
            end
            else if (sel_cfg1)
            begin
                s_d.prdata = s_q.cfg1 & `PCC_MASK_CFG1;
            end
            else if (sel_dsv)
            begin
                s_d.prdata = s_q.dsv & `PCC_MASK_DSV;
            end
            else
            begin
                s_d.prdata = 32'h0000_0000;
            end
        end
        s_d.pll_c_factor = pll_c_dec;
        s_d.pll_c_ok = pll_c_dec_ok;
        s_d.pll_b_factor = pll_b_dec;
        s_d.pll_b_ok = pll_b_dec_ok;
        s_d.prediv_a_div = div_ratio(s_q.cfg1[`PCC_MSB_PDA:`PCC_LSB_PDA]);
        s_d.prediv_b_div = div_ratio(s_q.cfg1[`PCC_MSB_PDB:`PCC_LSB_PDB]);
        s_d.adc_psc = {s_q.cfg1[`PCC_BIT_ADCMSB], cfg0_adc_psc_hi, cfg0_adc_psc_lo};
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & s_q.rd_err;
    assign prdata = s_q.prdata;

    assign usb_fs_core_reset = s_q.ahbrst[`PCC_BIT_USBRST];
    assign main_pll_source_select = s_q.cfg1[`PCC_BIT_PLLSRC];
    assign i2s_b_clock_select = s_q.cfg1[`PCC_BIT_I2SB];
    assign i2s_a_clock_select = s_q.cfg1[`PCC_BIT_I2SA];
    assign prediv_a_input_select = s_q.cfg1[`PCC_BIT_PDASEL];
    assign prediv_a_lsb = s_q.cfg1[`PCC_LSB_PDA];
    assign adc_prescaler = s_q.adc_psc;
    assign pll_c_multiplier = s_q.pll_c_factor;
    assign pll_c_multiplier_valid = s_q.pll_c_ok;
    assign pll_b_multiplier = s_q.pll_b_factor;
    assign pll_b_multiplier_valid = s_q.pll_b_ok;
    assign prediv_a_divisor = s_q.prediv_a_div;
    assign prediv_b_divisor = s_q.prediv_b_div;
    assign deep_sleep_core_voltage = s_q.dsv[`PCC_MSB_DSV:`PCC_LSB_DSV];

    // Checks

    a_usb_reset_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_ahbrst && pstrb[1])
        |=> (usb_fs_core_reset == $past(pwdata[12])))
        else $error("usb core reset did not follow write");

    a_usb_reset_lane: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_ahbrst && !pstrb[1])
        |=> $stable(usb_fs_core_reset))
        else $error("usb core reset changed without its lane");

    a_pll_src_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[3])
        |=> (main_pll_source_select == $past(pwdata[30])))
        else $error("pll source select did not follow write");

    a_i2s_sel_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[2])
        |=> (i2s_b_clock_select == $past(pwdata[18]))
            && (i2s_a_clock_select == $past(pwdata[17]))
            && (prediv_a_input_select == $past(pwdata[16])))
        else $error("clock select bits did not follow write");

    a_pll_c_x16: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[1] && pwdata[15:12] == 4'hE)
        |=> ##1 (pll_c_multiplier == 5'h10) && pll_c_multiplier_valid)
        else $error("pll c code 14 not decoded as 16");

    a_pll_b_reserved: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[1] && pwdata[11:8] == 4'hD)
        |=> ##1 !pll_b_multiplier_valid && (pll_b_multiplier == 5'h00))
        else $error("pll b reserved code not flagged");

    a_prediv_b_ratio: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[0])
        |=> ##1 (prediv_b_divisor == {1'b0, $past(pwdata[7:4], 2)} + 5'h01))
        else $error("pre-divider b ratio wrong");

    a_prediv_a_ratio: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[0] && !cfg0_prediv_lsb_we)
        |=> ##1 (prediv_a_divisor == {1'b0, $past(pwdata[3:0], 2)} + 5'h01))
        else $error("pre-divider a ratio wrong");

    a_prediv_shared: assert property (
        @(posedge ref_clk) disable iff (rst)
        cfg0_prediv_lsb_we
        |=> (prediv_a_lsb == $past(cfg0_prediv_lsb_wdata))
            && (s_q.cfg1[0] == prediv_a_lsb))
        else $error("shared pre-divider bit not updated");

    a_dsv_write: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_dsv && pstrb[0])
        |=> (deep_sleep_core_voltage == $past(pwdata[1:0])))
        else $error("deep-sleep voltage did not follow write");

    a_reset_clear: assert property (
        @(posedge ref_clk)
        $fell(rst)
        |-> (!usb_fs_core_reset && (deep_sleep_core_voltage == 2'h0)
            && !main_pll_source_select)
            ##1 ((prediv_a_divisor == 5'h01) && (prediv_b_divisor == 5'h01)))
        else $error("registers not cleared by reset");

    a_reserved_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        (psel && penable && !pwrite && sel_cfg1)
        |-> (prdata[31] == 1'b0) && (prdata[28:19] == 10'h000))
        else $error("reserved bits read non-zero");

    a_adc_msb: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[3])
        |=> ##1 (adc_prescaler[3] == $past(pwdata[29], 2)))
        else $error("adc prescaler top bit wrong");

    a_unmapped_err: assert property (
        @(posedge ref_clk) disable iff (rst)
        (setup && !(sel_ahbrst || sel_cfg1 || sel_dsv))
        ##1 (psel && penable)
        |-> pslverr && (prdata == 32'h0000_0000))
        else $error("unmapped access not refused");

    a_unmapped_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && !(sel_ahbrst || sel_cfg1 || sel_dsv))
        |=> $stable(usb_fs_core_reset) && $stable(deep_sleep_core_voltage)
            && $stable(main_pll_source_select))
        else $error("unmapped write changed a register");

    a_dsv_lane: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_dsv && !pstrb[0])
        |=> $stable(deep_sleep_core_voltage))
        else $error("deep-sleep voltage changed without its lane");

    a_cfg1_lane: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && !pstrb[3])
        |=> $stable(main_pll_source_select))
        else $error("pll source select changed without its lane");

    a_ahbrst_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        (psel && penable && !pwrite && sel_ahbrst)
        |-> (prdata[31:13] == 19'h00000) && (prdata[11:0] == 12'h000))
        else $error("reset register reserved bits read non-zero");

    a_dsv_read: assert property (
        @(posedge ref_clk) disable iff (rst)
        (psel && penable && !pwrite && sel_dsv)
        |-> (prdata[31:2] == 30'h0000_0000))
        else $error("voltage register reserved bits read non-zero");

    a_pll_c_x8: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[1] && pwdata[15:12] == 4'h6)
        |=> ##1 ((pll_c_multiplier == 5'h08) && pll_c_multiplier_valid))
        else $error("pll c code 6 not decoded as 8");

    a_pll_c_reserved: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[1] && pwdata[15:12] == 4'hD)
        |=> ##1 (!pll_c_multiplier_valid && (pll_c_multiplier == 5'h00)))
        else $error("pll c reserved code not flagged");

    a_pll_b_x20: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr_access && sel_cfg1 && pstrb[1] && pwdata[11:8] == 4'hF)
        |=> ##1 ((pll_b_multiplier == 5'h14) && pll_b_multiplier_valid))
        else $error("pll b code 15 not decoded as 20");

    a_adc_low_bits: assert property (
        @(posedge ref_clk) disable iff (rst)
        !rst
        |=> (adc_prescaler[2:0] == $past({cfg0_adc_psc_hi, cfg0_adc_psc_lo})))
        else $error("adc prescaler low bits wrong");

endmodule : pcc_regs

// *** pcc_regs_tb.sv ***
// Purpose: Self-checking bench for the clock config register slice
// Assumes: Zero-wait APB slave; outputs settle within two clocks of a write
// Notes: All stimulus by non-blocking assignment at the rising edge
`include "pcc_params.svh"

module pcc_regs_tb
    import pcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic cfg0_prediv_lsb_we = 1'b0;
    logic cfg0_prediv_lsb_wdata = 1'b0;
    logic cfg0_adc_psc_hi = 1'b0;
    logic [1:0] cfg0_adc_psc_lo = 2'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic usb_fs_core_reset;
    logic main_pll_source_select;
    logic i2s_b_clock_select;
    logic i2s_a_clock_select;
    logic prediv_a_input_select;
    logic prediv_a_lsb;
    logic [3:0] adc_prescaler;
    logic [4:0] pll_c_multiplier;
    logic pll_c_multiplier_valid;
    logic [4:0] pll_b_multiplier;
    logic pll_b_multiplier_valid;
    logic [4:0] prediv_a_divisor;
    logic [4:0] prediv_b_divisor;
    logic [1:0] deep_sleep_core_voltage;
    int fails = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic er;
    logic [5:0] mx;

    always #4 ref_clk = ~ref_clk;

    pcc_regs u_pcc_regs (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg0_prediv_lsb_we(cfg0_prediv_lsb_we),
        .cfg0_prediv_lsb_wdata(cfg0_prediv_lsb_wdata), .cfg0_adc_psc_hi(cfg0_adc_psc_hi),
        .cfg0_adc_psc_lo(cfg0_adc_psc_lo), .usb_fs_core_reset(usb_fs_core_reset),
        .main_pll_source_select(main_pll_source_select),
        .i2s_b_clock_select(i2s_b_clock_select), .i2s_a_clock_select(i2s_a_clock_select),
        .prediv_a_input_select(prediv_a_input_select), .prediv_a_lsb(prediv_a_lsb),
        .adc_prescaler(adc_prescaler), .pll_c_multiplier(pll_c_multiplier),
        .pll_c_multiplier_valid(pll_c_multiplier_valid), .pll_b_multiplier(pll_b_multiplier),
        .pll_b_multiplier_valid(pll_b_multiplier_valid), .prediv_a_divisor(prediv_a_divisor),
        .prediv_b_divisor(prediv_b_divisor), .deep_sleep_core_voltage(deep_sleep_core_voltage)
    );

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask : check

    // One APB transfer: setup, then access until pready is sampled high
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fails++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 4'hF);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000, 4'h0);
        check("prdata", rd, exp);
        check("pslverr", 32'(er), 32'h0000_0000);
    endtask : rdchk

    // Expected {valid, factor} of a multiplier code
    function automatic logic [5:0] mult_exp(input logic [3:0] c);
        logic [4:0] f;
        f = {1'b0, c} + 5'h02;
        if (c >= 4'h6 && c <= 4'hC)
            return {1'b1, f};
        if (c == 4'hE)
            return {1'b1, 5'h10};
        if (c == 4'hF)
            return {1'b1, 5'h14};
        return 6'h00;
    endfunction : mult_exp

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        rdchk(`PCC_OFF_AHBRST, 32'h0000_0000);
        rdchk(`PCC_OFF_CFG1, 32'h0000_0000);
        rdchk(`PCC_OFF_DSV, 32'h0000_0000);
        check("pdiv_a", 32'(prediv_a_divisor), 32'h0000_0001);
        mx = {pll_c_multiplier_valid, pll_c_multiplier};
        check("mult_c", 32'(mx), 32'h0000_0000);
        // All ones: only documented bits stick
        wr(`PCC_OFF_AHBRST, 32'hFFFF_FFFF);
        check("usb_rst", 32'(usb_fs_core_reset), 32'h0000_0001);
        rdchk(`PCC_OFF_AHBRST, 32'h0000_1000);
        wr(`PCC_OFF_CFG1, 32'hFFFF_FFFF);
        rdchk(`PCC_OFF_CFG1, 32'h6007_FFFF);
        wr(`PCC_OFF_DSV, 32'hFFFF_FFFF);
        rdchk(`PCC_OFF_DSV, 32'h0000_0003);
        wr(`PCC_OFF_AHBRST, 32'h0000_0000);
        check("usb_rst", 32'(usb_fs_core_reset), 32'h0000_0000);
        // Single-bit selects walk one at a time, reserved bits written as zero
        for (int i = 0; i < 4; i++)
        begin
            wr(`PCC_OFF_CFG1, 32'h4000_0000 >> (i == 0 ? 0 : 11 + i));
            check("pll_src", 32'(main_pll_source_select), 32'(i == 0));
            check("i2s_b", 32'(i2s_b_clock_select), 32'(i == 1));
            check("i2s_a", 32'(i2s_a_clock_select), 32'(i == 2));
            check("pda_sel", 32'(prediv_a_input_select), 32'(i == 3));
        end
        // Every multiplier code and every divider value
        for (int i = 0; i < 16; i++)
        begin
            wr(`PCC_OFF_CFG1, {16'h0000, 4'(i), 4'(15 - i), 4'(i), 4'(15 - i)});
            mx = {pll_c_multiplier_valid, pll_c_multiplier};
            check("mult_c", 32'(mx), 32'(mult_exp(4'(i))));
            mx = {pll_b_multiplier_valid, pll_b_multiplier};
            check("mult_b", 32'(mx), 32'(mult_exp(4'(15 - i))));
            check("pdiv_b", 32'(prediv_b_divisor), 32'(i + 1));
            check("pdiv_a", 32'(prediv_a_divisor), 32'(16 - i));
        end
        // ADC prescaler assembled from both registers
        @(posedge ref_clk);
        cfg0_adc_psc_lo <= 2'h1;
        wr(`PCC_OFF_CFG1, 32'h2000_0000);
        check("adc_psc", 32'(adc_prescaler), 32'h0000_0009);
        @(posedge ref_clk);
        cfg0_adc_psc_hi <= 1'b1;
        cfg0_adc_psc_lo <= 2'h2;
        wr(`PCC_OFF_CFG1, 32'h0000_0000);
        check("adc_psc", 32'(adc_prescaler), 32'h0000_0006);
        // Shared pre-divider bit written from the first config side
        @(posedge ref_clk);
        cfg0_prediv_lsb_we <= 1'b1;
        cfg0_prediv_lsb_wdata <= 1'b1;
        @(posedge ref_clk);
        cfg0_prediv_lsb_we <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("pda_lsb", 32'(prediv_a_lsb), 32'h0000_0001);
        check("pdiv_a", 32'(prediv_a_divisor), 32'h0000_0002);
        rdchk(`PCC_OFF_CFG1, 32'h0000_0001);
        wr(`PCC_OFF_CFG1, 32'h0000_0000);
        check("pda_lsb", 32'(prediv_a_lsb), 32'h0000_0000);
        // Byte lanes: only strobed lanes change
        xfer(`PCC_OFF_AHBRST, 1'b1, 32'h0000_1000, 4'h1);
        rdchk(`PCC_OFF_AHBRST, 32'h0000_0000);
        xfer(`PCC_OFF_AHBRST, 1'b1, 32'h0000_1000, 4'h2);
        rdchk(`PCC_OFF_AHBRST, 32'h0000_1000);
        xfer(`PCC_OFF_CFG1, 1'b1, 32'hFFFF_FFFF, 4'h4);
        rdchk(`PCC_OFF_CFG1, 32'h0007_0000);
        // Voltage field still holds 3 from the all-ones write; lane 0 is not strobed
        xfer(`PCC_OFF_DSV, 1'b1, 32'h0000_0000, 4'hE);
        rdchk(`PCC_OFF_DSV, 32'h0000_0003);
        // Every deep-sleep voltage code
        for (int i = 0; i < 4; i++)
        begin
            wr(`PCC_OFF_DSV, 32'(i));
            check("dsv", 32'(deep_sleep_core_voltage), 32'(i));
        end
        // Unmapped word answers an error and reads zero
        xfer(12'h030, 1'b1, 32'hFFFF_FFFF, 4'hF);
        check("wr_err", 32'(er), 32'h0000_0001);
        xfer(12'h030, 1'b0, 32'h0000_0000, 4'h0);
        check("rd_data", rd, 32'h0000_0000);
        check("rd_err", 32'(er), 32'h0000_0001);
        // Second reset clears everything
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(`PCC_OFF_AHBRST, 32'h0000_0000);
        rdchk(`PCC_OFF_DSV, 32'h0000_0000);
        rdchk(`PCC_OFF_CFG1, 32'h0000_0000);
        check("i2s_b", 32'(i2s_b_clock_select), 32'h0000_0000);
        check("usb_rst", 32'(usb_fs_core_reset), 32'h0000_0000);
        conclude();
    end
endmodule : pcc_regs_tb
